/* File: edge_capture_status.sv */
// Operation
// - in repetitive-done, every further trigger recaptures and overwrites results
// - overwriting unread results raises no flag of any kind
// - repetitive-done returns to repetitive-armed when any result is read
// - single-shot done reports 19 falling, 35 rising, 51 both edges
// - single-done states ignore triggers; host may then disable the unit
// - repetitive done reports 20 on falling edge, 36 on rising edge
// - read-only 16-bit total capture counter
// - read-only 16-bit counter of rising-edge captures
// - read-only 16-bit counter of falling-edge captures
// - rising capture stores three signed 32-bit quantities in rising set
// - falling capture stores three signed 32-bit quantities in falling set
// - each result set reports a constant entry count of three
// - edge select 0 falling, 1 rising, 2 both
// - repetitive-armed waits for trigger, stores data, enters repetitive-done
// - after a trigger, same edge ignored for holdoff ms, per edge
//
// Purpose: state, counters and per-edge result sets of one capture unit
// Assumes: all inputs synchronous to clk; reads over a 16-bit word port
// Notes:   holdoff counts on a free-running ms tick, so it may end up to
//          one ms early; trades precision for one shared prescaler
`timescale 1ns/1ps

module edge_capture_status
  import edge_capture_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  unit_command,
  input  wire logic [1:0]  trigger_edge_select,
  input  wire logic [15:0] retrigger_holdoff_time,
  input  wire logic        trigger_level,
  input  wire logic [31:0] quantity_first,
  input  wire logic [31:0] quantity_second,
  input  wire logic [31:0] quantity_third,
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic      [5:0]  unit_state_code,
  output logic      [7:0]  rise_set_entry_count,
  output logic      [7:0]  fall_set_entry_count
);

  typedef struct packed {
    unit_state_t state;
    logic        trig_prev;
    logic [31:0] tick_cnt;
    logic [15:0] hold_rise;
    logic [15:0] hold_fall;
    logic [15:0] total_cnt;
    logic [15:0] rise_cnt;
    logic [15:0] fall_cnt;
    logic [31:0] rise_first;
    logic [31:0] rise_second;
    logic [31:0] rise_third;
    logic [31:0] fall_first;
    logic [31:0] fall_second;
    logic [31:0] fall_third;
    logic [15:0] rd_data;
    logic        rd_valid;
  } regs_t;

  regs_t r_r;
  regs_t r_nxt;

  logic        tick;
  logic        rise_seen;
  logic        fall_seen;
  logic        rise_take;
  logic        fall_take;
  logic        capture_ok;
  logic        result_read;
  logic [15:0] rd_word;

  always_comb begin
    r_nxt = r_r;

    // shared millisecond prescaler
    tick = (r_r.tick_cnt == TICK_CYCLES - 1);
    if (tick) begin
      r_nxt.tick_cnt = 32'h0000_0000;
    end else begin
      r_nxt.tick_cnt = r_r.tick_cnt + 32'h0000_0001;
    end

    r_nxt.trig_prev = trigger_level;
    rise_seen = trigger_level & ~r_r.trig_prev;
    fall_seen = ~trigger_level & r_r.trig_prev;

    // only armed and repetitive-done states accept triggers
    capture_ok = (r_r.state == ST_SINGLE_ARM) ||
                 (r_r.state == ST_REPEAT_ARM) ||
                 (r_r.state == ST_REPEAT_FALL) ||
                 (r_r.state == ST_REPEAT_RISE);

    rise_take = rise_seen && capture_ok && (r_r.hold_rise == 16'h0000) &&
                ((trigger_edge_select == EDGE_RISE) ||
                 (trigger_edge_select == EDGE_BOTH));
    fall_take = fall_seen && capture_ok && (r_r.hold_fall == 16'h0000) &&
                ((trigger_edge_select == EDGE_FALL) ||
                 (trigger_edge_select == EDGE_BOTH));

    // holdoff per edge; the other edge is untouched
    if (rise_take) begin
      r_nxt.hold_rise = retrigger_holdoff_time;
    end else if (tick && r_r.hold_rise != 16'h0000) begin
      r_nxt.hold_rise = r_r.hold_rise - 16'h0001;
    end
    if (fall_take) begin
      r_nxt.hold_fall = retrigger_holdoff_time;
    end else if (tick && r_r.hold_fall != 16'h0000) begin
      r_nxt.hold_fall = r_r.hold_fall - 16'h0001;
    end

    // results are replaced silently; no overrun status exists
    if (rise_take) begin
      r_nxt.rise_first  = quantity_first;
      r_nxt.rise_second = quantity_second;
      r_nxt.rise_third  = quantity_third;
      r_nxt.rise_cnt    = r_r.rise_cnt + 16'h0001;
    end
    if (fall_take) begin
      r_nxt.fall_first  = quantity_first;
      r_nxt.fall_second = quantity_second;
      r_nxt.fall_third  = quantity_third;
      r_nxt.fall_cnt    = r_r.fall_cnt + 16'h0001;
    end
    if (rise_take || fall_take) begin
      r_nxt.total_cnt = r_r.total_cnt + 16'h0001;
    end

    // register read port, low word at offset, high word at offset+1
    case (rd_addr)
      OFS_STATE:              rd_word = {10'h000, r_r.state};
      OFS_TOTAL_COUNT:        rd_word = r_r.total_cnt;
      OFS_RISE_COUNT:         rd_word = r_r.rise_cnt;
      OFS_FALL_COUNT:         rd_word = r_r.fall_cnt;
      OFS_RISE_FIRST:         rd_word = r_r.rise_first[15:0];
      OFS_RISE_FIRST + 16'h1: rd_word = r_r.rise_first[31:16];
      OFS_RISE_SECOND:        rd_word = r_r.rise_second[15:0];
      OFS_RISE_SECOND + 16'h1:rd_word = r_r.rise_second[31:16];
      OFS_RISE_THIRD:         rd_word = r_r.rise_third[15:0];
      OFS_RISE_THIRD + 16'h1: rd_word = r_r.rise_third[31:16];
      OFS_FALL_FIRST:         rd_word = r_r.fall_first[15:0];
      OFS_FALL_FIRST + 16'h1: rd_word = r_r.fall_first[31:16];
      OFS_FALL_SECOND:        rd_word = r_r.fall_second[15:0];
      OFS_FALL_SECOND + 16'h1:rd_word = r_r.fall_second[31:16];
      OFS_FALL_THIRD:         rd_word = r_r.fall_third[15:0];
      OFS_FALL_THIRD + 16'h1: rd_word = r_r.fall_third[31:16];
      default:                rd_word = 16'h0000;
    endcase
    r_nxt.rd_valid = rd_en;
    if (rd_en) begin
      r_nxt.rd_data = rd_word;
    end
    result_read = rd_en && (rd_addr >= OFS_RISE_FIRST) &&
                  (rd_addr <= OFS_RESULT_LAST);

    // unit state; a new capture wins over a same-cycle read
    case (r_r.state)
      ST_STOP: begin
        if (unit_command == CMD_SINGLE) begin
          r_nxt.state = ST_SINGLE_ARM;
        end else if (unit_command == CMD_REPEAT) begin
          r_nxt.state = ST_REPEAT_ARM;
        end
      end
      ST_SINGLE_ARM: begin
        if (trigger_edge_select == EDGE_BOTH && (rise_take || fall_take)) begin
          r_nxt.state = ST_SINGLE_BOTH;
        end else if (rise_take) begin
          r_nxt.state = ST_SINGLE_RISE;
        end else if (fall_take) begin
          r_nxt.state = ST_SINGLE_FALL;
        end
      end
      ST_REPEAT_ARM, ST_REPEAT_FALL, ST_REPEAT_RISE: begin
        if (rise_take) begin
          r_nxt.state = ST_REPEAT_RISE;
        end else if (fall_take) begin
          r_nxt.state = ST_REPEAT_FALL;
        end else if (result_read && r_r.state != ST_REPEAT_ARM) begin
          r_nxt.state = ST_REPEAT_ARM;
        end
      end
      ST_SINGLE_FALL, ST_SINGLE_RISE, ST_SINGLE_BOTH: begin
        r_nxt.state = r_r.state;
      end
      default: begin
        r_nxt.state = ST_STOP;
      end
    endcase
    // stop command disables the unit from any state
    if (unit_command == CMD_STOP) begin
      r_nxt.state = ST_STOP;
    end else if (r_r.state == ST_SINGLE_ARM && unit_command == CMD_REPEAT) begin
      r_nxt.state = ST_REPEAT_ARM;
    end else if (r_r.state == ST_REPEAT_ARM && unit_command == CMD_SINGLE) begin
      r_nxt.state = ST_SINGLE_ARM;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_r.state       <= ST_STOP;
      r_r.trig_prev   <= 1'b0;
      r_r.tick_cnt    <= 32'h0000_0000;
      r_r.hold_rise   <= 16'h0000;
      r_r.hold_fall   <= 16'h0000;
      r_r.total_cnt   <= COUNT_RESET;
      r_r.rise_cnt    <= COUNT_RESET;
      r_r.fall_cnt    <= COUNT_RESET;
      r_r.rise_first  <= RESULT_RESET;
      r_r.rise_second <= RESULT_RESET;
      r_r.rise_third  <= RESULT_RESET;
      r_r.fall_first  <= RESULT_RESET;
      r_r.fall_second <= RESULT_RESET;
      r_r.fall_third  <= RESULT_RESET;
      r_r.rd_data     <= 16'h0000;
      r_r.rd_valid    <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rd_data              = r_r.rd_data;
  assign rd_valid             = r_r.rd_valid;
  assign unit_state_code      = r_r.state;
  assign rise_set_entry_count = SET_ENTRY_COUNT;
  assign fall_set_entry_count = SET_ENTRY_COUNT;

endmodule

/* File: edge_capture_pkg.sv */
// Purpose: shared constants and types of the edge capture status block
// Assumes: 16-bit register words, 32-bit results split over two words
// Notes:   low word of a result sits at its offset, high word at offset+1
package edge_capture_pkg;

  localparam logic [15:0] OFS_STATE       = 16'h0af0;
  localparam logic [15:0] OFS_TOTAL_COUNT = 16'h0afe;
  localparam logic [15:0] OFS_RISE_COUNT  = 16'h0aff;
  localparam logic [15:0] OFS_FALL_COUNT  = 16'h0b00;
  localparam logic [15:0] OFS_RISE_FIRST  = 16'h0b04;
  localparam logic [15:0] OFS_RISE_SECOND = 16'h0b06;
  localparam logic [15:0] OFS_RISE_THIRD  = 16'h0b08;
  localparam logic [15:0] OFS_FALL_FIRST  = 16'h0b0a;
  localparam logic [15:0] OFS_FALL_SECOND = 16'h0b0c;
  localparam logic [15:0] OFS_FALL_THIRD  = 16'h0b0e;
  localparam logic [15:0] OFS_RESULT_LAST = 16'h0b0f;

  localparam logic [7:0]  SET_ENTRY_COUNT = 8'h03;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [31:0] RESULT_RESET    = 32'h0000_0000;

  // edge selection codes
  localparam logic [1:0]  EDGE_FALL = 2'h0;
  localparam logic [1:0]  EDGE_RISE = 2'h1;
  localparam logic [1:0]  EDGE_BOTH = 2'h2;

  // unit command codes
  localparam logic [1:0]  CMD_STOP   = 2'h0;
  localparam logic [1:0]  CMD_SINGLE = 2'h1;
  localparam logic [1:0]  CMD_REPEAT = 2'h2;

  // timing: one millisecond of the 20 MHz clock
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  typedef enum logic [5:0] {
    ST_STOP        = 6'b00_0000,
    ST_SINGLE_ARM  = 6'b00_0001,
    ST_REPEAT_ARM  = 6'b00_0010,
    ST_SINGLE_FALL = 6'b01_0011,
    ST_SINGLE_RISE = 6'b10_0011,
    ST_SINGLE_BOTH = 6'b11_0011,
    ST_REPEAT_FALL = 6'b01_0100,
    ST_REPEAT_RISE = 6'b10_0100
  } unit_state_t;

endpackage

/* File: edge_capture_status_properties.sv */
// Purpose: port checks of the edge capture status block
// Assumes: bound to every instance of edge_capture_status
// Notes:   capture latency allowed one or two edges, read answer one edge
`timescale 1ns/1ps
module edge_capture_props
  import edge_capture_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [1:0]  unit_command,
  input wire logic [1:0]  trigger_edge_select,
  input wire logic [15:0] retrigger_holdoff_time,
  input wire logic        trigger_level,
  input wire logic        rd_en,
  input wire logic [15:0] rd_addr,
  input wire logic        rd_valid,
  input wire logic [5:0]  unit_state_code,
  input wire logic [7:0]  rise_set_entry_count,
  input wire logic [7:0]  fall_set_entry_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd_res;
  assign rd_res = rd_en && rd_addr >= OFS_RISE_FIRST
                  && rd_addr <= OFS_RESULT_LAST;
  chk_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  chk_valid_only: assert property (!rd_en |=> !rd_valid)
    else $error("answer without read");
  chk_entry_const: assert property (rise_set_entry_count == 8'h03
    && fall_set_entry_count == 8'h03) else $error("entry count wrong");
  chk_stop_cmd: assert property (unit_command == CMD_STOP
    |=> unit_state_code == ST_STOP) else $error("stop not taken");
  chk_single_hold: assert property (unit_command != CMD_STOP
    && unit_state_code inside {6'h13, 6'h23, 6'h33}
    |=> $stable(unit_state_code)) else $error("single done left");
  chk_rise_capture: assert property ($rose(trigger_level)
    && unit_state_code == 6'h02 && unit_command == CMD_REPEAT
    && trigger_edge_select == 2'h1 && retrigger_holdoff_time == 16'h0000
    |-> ##[1:2] unit_state_code == 6'h24) else $error("rise missed");
  chk_fall_capture: assert property ($fell(trigger_level)
    && unit_state_code == 6'h02 && unit_command == CMD_REPEAT
    && trigger_edge_select == 2'h0 && retrigger_holdoff_time == 16'h0000
    |-> ##[1:2] unit_state_code == 6'h14) else $error("fall missed");
  chk_read_rearm: assert property (rd_res && $stable(trigger_level)
    && $past(trigger_level) == $past(trigger_level, 2)
    && unit_command == CMD_REPEAT && unit_state_code inside {6'h14, 6'h24}
    |=> unit_state_code == 6'h02) else $error("read did not rearm");
endmodule

bind edge_capture_status edge_capture_props u_props (
  .clk, .resetn, .unit_command, .trigger_edge_select,
  .retrigger_holdoff_time, .trigger_level, .rd_en, .rd_addr, .rd_valid,
  .unit_state_code, .rise_set_entry_count, .fall_set_entry_count
);

/* File: trigger_source_model.sv */
// Purpose: trigger input and sampled quantities seen by the capture unit
// Assumes: trigger already synchronised to clk by the input stage
// Notes:   third quantity negated so the sign of results is exercised
`timescale 1ns/1ps
module trigger_source_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        level_req,
  input  wire logic [31:0] base,
  output logic             trigger_level,
  output logic      [31:0] quantity_first,
  output logic      [31:0] quantity_second,
  output logic      [31:0] quantity_third
);
  // pin moves only on an edge, as a synchronised input would
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) trigger_level <= 1'b0;
    else trigger_level <= level_req;
  end
  assign quantity_first  = base;
  assign quantity_second = base + 32'h0000_0001;
  assign quantity_third  = -base;
endmodule

/* File: tb_edge_capture_status.sv */
// Purpose: self-checking bench of the edge capture status block
// Assumes: holdoff tick shortened to 4 cycles per ms
// Notes:   each scenario task checks what it drove before returning
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_edge_capture_status
  import edge_capture_pkg::*;
;
  logic clk, resetn, trigger_level, rd_en, rd_valid, level_req;
  logic [1:0]  unit_command, trigger_edge_select;
  logic [15:0] retrigger_holdoff_time, rd_addr, rd_data;
  logic [31:0] quantity_first, quantity_second, quantity_third, base;
  logic [5:0]  unit_state_code;
  logic [7:0]  rise_set_entry_count, fall_set_entry_count;
  int fails = 0;
  int cmp_count = 0;
  edge_capture_status #(.TICK_CYCLES(4)) DUT (.clk, .resetn, .unit_command,
    .trigger_edge_select, .retrigger_holdoff_time, .trigger_level,
    .quantity_first, .quantity_second, .quantity_third, .rd_en, .rd_addr,
    .rd_data, .rd_valid, .unit_state_code, .rise_set_entry_count,
    .fall_set_entry_count);
  trigger_source_model u_src (.clk, .resetn, .level_req, .base,
    .trigger_level, .quantity_first, .quantity_second, .quantity_third);
  task automatic rd(input logic [15:0] a, e, input string n);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(n, e, rd_data)
    `CHK(n, 1'b1, rd_valid)
  endtask
  task automatic rd32(input logic [15:0] a, input logic [31:0] e,
                      input string n);
    rd(a, e[15:0], n);
    rd(a + 16'h0001, e[31:16], n);
  endtask
  task automatic trig(input logic lvl, input logic [31:0] b);
    @(posedge clk);
    level_req <= lvl;
    base <= b;
    repeat (4) @(posedge clk);
  endtask
  task automatic arm(input logic [1:0] cmd, sel);
    @(posedge clk);
    unit_command <= CMD_STOP;
    @(posedge clk);
    unit_command <= cmd;
    trigger_edge_select <= sel;
    @(posedge clk);
  endtask
  task automatic t_reset();
    rd(OFS_STATE, 16'h0000, "reset state");
    `CHK("state port", 6'h00, unit_state_code)
    rd(OFS_TOTAL_COUNT, 16'h0000, "total");
    rd(OFS_RISE_COUNT, 16'h0000, "rise count");
    rd(OFS_FALL_COUNT, 16'h0000, "fall count");
    `CHK("rise entries", 8'h03, rise_set_entry_count)
    `CHK("fall entries", 8'h03, fall_set_entry_count)
  endtask
  // two rises without a read: second overwrites, no other indication
  task automatic t_repeat();
    arm(CMD_REPEAT, EDGE_RISE);
    rd(OFS_STATE, 16'h0002, "armed");
    trig(1'b1, 32'h1111_2222);
    trig(1'b0, 32'h1111_2222);
    trig(1'b1, 32'h8765_4321);
    rd(OFS_STATE, 16'h0024, "rise done");
    rd(OFS_RISE_COUNT, 16'h0002, "rise count");
    rd(OFS_TOTAL_COUNT, 16'h0002, "total");
    rd32(OFS_RISE_FIRST, 32'h8765_4321, "rise first");
    rd32(OFS_RISE_THIRD, 32'h789a_bcdf, "rise third");
    rd32(OFS_RISE_SECOND, 32'h8765_4322, "rise second");
    rd(OFS_STATE, 16'h0002, "rearmed");
  endtask
  task automatic t_fall();
    @(posedge clk);
    trigger_edge_select <= EDGE_FALL;
    trig(1'b0, 32'h0000_0c0c);
    rd(OFS_STATE, 16'h0014, "fall done");
    rd(OFS_FALL_COUNT, 16'h0001, "fall count");
    rd32(OFS_FALL_SECOND, 32'h0000_0c0d, "fall second");
    rd32(OFS_FALL_FIRST, 32'h0000_0c0c, "fall first");
    rd32(OFS_FALL_THIRD, 32'hffff_f3f4, "fall third");
    rd32(OFS_RISE_FIRST, 32'h8765_4321, "rise kept");
  endtask
  task automatic t_single();
    logic [1:0] sel [3];
    logic [15:0] code [3];
    logic [2:0] pre;
    sel = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
    code = '{16'h0013, 16'h0023, 16'h0033};
    pre = 3'b001;
    for (int i = 0; i < 3; i++) begin
      arm(CMD_STOP, sel[i]);
      trig(pre[i], 32'h0000_0010);
      arm(CMD_SINGLE, sel[i]);
      trig(!pre[i], 32'h0000_0010);
      trig(pre[i], 32'h0000_0020);
      rd(OFS_STATE, code[i], "single done");
      rd(OFS_TOTAL_COUNT, 16'(4 + i), "single total");
    end
  endtask
  // 5 ms of 4-cycle ticks: re-edge after ~14 cycles is inside holdoff
  task automatic t_holdoff();
    @(posedge clk);
    retrigger_holdoff_time <= 16'h0005;
    arm(CMD_REPEAT, EDGE_RISE);
    trig(1'b1, 32'h0000_0d0d);
    rd32(OFS_RISE_FIRST, 32'h0000_0d0d, "held first");
    trig(1'b0, 32'h0000_0e0e);
    trig(1'b1, 32'h0000_0e0e);
    rd(OFS_TOTAL_COUNT, 16'h0007, "blocked total");
    rd(OFS_STATE, 16'h0002, "blocked state");
    repeat (30) @(posedge clk);
    trig(1'b0, 32'h0000_0f0f);
    trig(1'b1, 32'h0000_0f0f);
    rd(OFS_TOTAL_COUNT, 16'h0008, "late total");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole run is some 225 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    unit_command = CMD_STOP;
    trigger_edge_select = EDGE_RISE;
    retrigger_holdoff_time = 16'h0000;
    level_req = 1'b0;
    base = 32'h0000_0000;
    rd_en = 1'b0;
    rd_addr = 16'h0000;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_repeat();
    t_fall();
    t_single();
    t_holdoff();
    complete_run();
  end
endmodule
